// ===== bench/sdec_decoder_asserts.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module sdec_decoder_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_start,
  input wire logic ev_valid,
  input wire logic ev_ready,
  input wire sdec_pkg::sdec_event_s ev_data,
  input wire logic format_error,
  input wire logic [15:0] pdu_tid,
  input wire logic [7:0] pdu_id,
  input wire logic pdu_id_reserved
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = rx_valid && rx_ready && !rx_start;
  sequence s_hdr;
    rx_start ##1 take[*5];
  endsequence
  property p_id; rx_start ##1 take |=> pdu_id == $past(rx_data); endproperty
  a_id: assert property (p_id) else $error("pdu id not captured");
  property p_tid; rx_start ##1 take[*3] |=> pdu_tid == {$past(rx_data, 2), $past(rx_data)}; endproperty
  a_tid: assert property (p_tid) else $error("transaction id order wrong");
  property p_rsv; pdu_id_reserved == (pdu_id == 8'h00 || pdu_id > 8'h07); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved id flag wrong");
  property p_ev; rx_start ##1 take |=> ev_valid; endproperty
  a_ev: assert property (p_ev) else $error("no event after id byte");
  property p_hold; ev_valid && !ev_ready |=> ev_valid && $stable(ev_data); endproperty
  a_hold: assert property (p_hold) else $error("event dropped while stalled");
  property p_clr; rx_start |=> !format_error; endproperty
  a_clr: assert property (p_clr) else $error("start did not clear error");
  property p_stick; format_error && !rx_start |=> format_error; endproperty
  a_stick: assert property (p_stick) else $error("error flag not sticky");
  property p_rtype; s_hdr ##1 (take && rx_data[7:3] > 5'h08) |=> ##[0:1] format_error; endproperty
  a_rtype: assert property (p_rtype) else $error("reserved type not flagged");
  property p_nil; s_hdr ##1 (take && rx_data[7:3] == 5'h00 && rx_data[2:0] != 3'h0) |=> ##[0:1] format_error;
  endproperty
  a_nil: assert property (p_nil) else $error("bad null size not flagged");
  cover property (s_hdr);
  cover property (format_error);
  cover property (!rx_ready);
endmodule
bind sdec_decoder sdec_decoder_asserts i_sdec_decoder_asserts (.clock, .reset_n, .rx_valid, .rx_ready,
  .rx_data, .rx_start, .ev_valid, .ev_ready, .ev_data, .format_error, .pdu_tid, .pdu_id, .pdu_id_reserved);

// ===== bench/sdec_peer.sv
// far-side byte source model
`timescale 1ns/1ps
module sdec_peer (
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
  end
  // bytes leave in call order, all eight bits in parallel
  task automatic put(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    @(posedge clock);
    #1;
  endtask
  // valid dropped after each burst, line scrambled when idle
  task automatic idle();
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
endmodule

// ===== bench/service_discovery_element_codec_test.sv
// self-checking bench for the element decoder
`timescale 1ns/1ps
module service_discovery_element_codec_test;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic rx_start = 1'b0;
  logic ev_ready = 1'b0;
  logic rx_valid, rx_ready, ev_valid, format_error, pdu_id_reserved;
  logic [7:0] rx_data, pdu_id;
  logic [15:0] pdu_tid;
  sdec_pkg::sdec_event_s ev_data;
  int failures = 0;
  int tests_run = 0;
  always #4 clock = ~clock;
  sdec_decoder i_sdec_decoder (.clock(clock), .reset_n(reset_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_start(rx_start), .ev_valid(ev_valid), .ev_ready(ev_ready), .ev_data(ev_data),
    .format_error(format_error), .pdu_tid(pdu_tid), .pdu_id(pdu_id), .pdu_id_reserved(pdu_id_reserved));
  sdec_peer i_sdec_peer (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data));
  task automatic summarize();
    if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic stuck(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      summarize();
    end
  endtask
  task automatic burst(input logic [7:0] q[$]);
    foreach (q[i]) begin
      for (int n = 0; n < 50 && !rx_ready; n++) tick();
      stuck(rx_ready);
      i_sdec_peer.put(q[i]);
    end
    i_sdec_peer.idle();
  endtask
  task automatic start();
    rx_start = 1'b1;
    tick();
    rx_start = 1'b0;
  endtask
  // value is {type,size} for headers, the byte otherwise
  task automatic pop(input logic [2:0] k, input logic [7:0] v, input logic [2:0] d);
    for (int n = 0; n < 50 && !ev_valid; n++) tick();
    stuck(ev_valid);
    check("kind", ev_data.kind, k);
    if (k == sdec_pkg::SDEC_K_HDR) begin
      check("header", {ev_data.elem_type, ev_data.size_idx}, v);
      check("depth", ev_data.depth, d);
    end else check("data", ev_data.data, v);
    ev_ready = 1'b1;
    tick();
    ev_ready = 1'b0;
    // gap cycle so a following pop does not re-drive ready at once
    tick();
  endtask
  task automatic fill_and_drain();
    start();
    burst('{8'h06, 8'h12, 8'h34, 8'h00, 8'h20, 8'h0B, 8'hB0, 8'hB1});
    tick();
    check("pdu_id", pdu_id, 8'h06);
    check("pdu_tid", pdu_tid, 16'h1234);
    check("reserved", pdu_id_reserved, 1'b0);
    check("rx_ready full", rx_ready, 1'b0);
    pop(3'h0, 8'h06, 3'h0);
    pop(3'h1, 8'h12, 3'h0);
    pop(3'h1, 8'h34, 3'h0);
    pop(3'h2, 8'h00, 3'h0);
    pop(3'h2, 8'h20, 3'h0);
    pop(3'h3, 8'h0B, 3'h0);
    for (int i = 0; i < 8; i++) begin
      if (i > 1) burst('{8'hB0 + 8'(i)});
      pop(3'h4, 8'hB0 + 8'(i), 3'h0);
    end
  endtask
  task automatic pdu_ids();
    ev_ready = 1'b1;
    for (int i = 0; i < 9; i++) begin
      start();
      burst('{8'(i)});
      tick();
      check("pdu_id", pdu_id, 8'(i));
      check("reserved", pdu_id_reserved, i == 0 || i > 7);
    end
  endtask
  task automatic pairs();
    // byte value and whether a format error is due
    logic [8:0] t[$] = '{9'h000, 9'h101, 9'h028, 9'h129, 9'h00C, 9'h10D, 9'h014, 9'h115, 9'h019, 9'h118, 9'h11B,
      9'h025, 9'h124, 9'h035, 9'h134, 9'h03D, 9'h13C, 9'h045, 9'h144, 9'h148, 9'h1FA};
    ev_ready = 1'b1;
    foreach (t[i]) begin
      start();
      burst('{8'h02, 8'h00, 8'h01, 8'h00, 8'h20, t[i][7:0]});
      tick();
      tick();
      check("format_error", format_error, t[i][8]);
      start();
      check("error cleared", format_error, 1'b0);
      tick();
    end
    ev_ready = 1'b0;
  endtask
  task automatic nesting();
    logic [7:0] h[$] = '{8'h07, 8'hAB, 8'hCD, 8'h00, 8'h06};
    start();
    burst(h);
    check("pdu_tid", pdu_tid, 16'hABCD);
    for (int i = 0; i < 5; i++) pop(3'(i > 2 ? 2 : i > 0), h[i], 3'h0);
    burst('{8'h36, 8'h00, 8'h02, 8'h08, 8'h11});
    pop(3'h3, 8'h36, 3'h0);
    pop(3'h2, 8'h00, 3'h0);
    check("length", ev_data.length, 32'h2);
    check("length last", ev_data.last, 1'b1);
    pop(3'h2, 8'h02, 3'h0);
    pop(3'h3, 8'h08, 3'h1);
    pop(3'h4, 8'h11, 3'h1);
  endtask
  task automatic cut_and_reset();
    start();
    burst('{8'h04});
    start();
    burst('{8'h04, 8'h00, 8'h09, 8'h00, 8'h01, 8'h28, 8'h08});
    tick();
    check("pdu_id", pdu_id, 8'h04);
    check("pdu_tid", pdu_tid, 16'h0009);
    check("plen overrun", format_error, 1'b1);
    pop(3'h0, 8'h04, 3'h0);
    pop(3'h0, 8'h04, 3'h0);
    pop(3'h1, 8'h00, 3'h0);
    pop(3'h1, 8'h09, 3'h0);
    pop(3'h2, 8'h00, 3'h0);
    pop(3'h2, 8'h01, 3'h0);
    pop(3'h3, 8'h28, 3'h0);
    check("event error", ev_data.error, 1'b1);
    pop(3'h4, 8'h08, 3'h0);
    reset_n = 1'b0;
    tick();
    check("reset rx_ready", rx_ready, 1'b1);
    check("reset ev_valid", ev_valid, 1'b0);
    check("reset error", format_error, 1'b0);
    check("reset pdu_id", pdu_id, 8'h00);
    check("reset pdu_tid", pdu_tid, 16'h0000);
    check("reset reserved", pdu_id_reserved, 1'b1);
    reset_n = 1'b1;
    tick();
    burst('{8'h03});
    tick();
    check("id after reset", pdu_id, 8'h03);
    check("reserved after reset", pdu_id_reserved, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    tick();
    fill_and_drain();
    pdu_ids();
    pairs();
    nesting();
    cut_and_reset();
    summarize();
  end
endmodule

// ===== verilog/sdec_decoder.sv
// byte-serial decoder of pdu headers and nested data elements
`timescale 1ns/1ps
`include "sdec_defines.svh"
module sdec_decoder (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_start,
  output logic ev_valid,
  input wire logic ev_ready,
  output sdec_pkg::sdec_event_s ev_data,
  output logic format_error,
  output logic [15:0] pdu_tid,
  output logic [7:0] pdu_id,
  output logic pdu_id_reserved
);
  localparam int ND = `SDEC_NEST_DEPTH;
  sdec_pkg::sdec_state_e state_q;
  logic [2:0] cnt_q;
  logic [4:0] type_q;
  logic [2:0] size_q;
  logic [31:0] len_q;
  logic [15:0] plen_q;
  logic [7:0] pid_q;
  logic [15:0] tid_q;
  logic [2:0] depth_q;
  logic [31:0] remain_q [ND];
  logic err_q;
  logic fifo_ready;
  logic take;
  logic push;
  sdec_pkg::sdec_event_s ev_d;
  logic [4:0] hdr_type;
  logic [2:0] hdr_size;
  logic size_ok;
  logic [31:0] fixed_len;
  logic [2:0] len_bytes;
  logic [31:0] len_next;
  logic parent_overrun;
  logic elem_done;
  logic plen_over;

  // back-pressure from the event fifo stalls the byte input
  assign rx_ready = fifo_ready;
  // start wins over a byte offered in the same cycle
  assign take = rx_valid && rx_ready && !rx_start;
  assign push = take && (state_q != sdec_pkg::SDEC_S_SKIP);

  assign hdr_type = rx_data[7:`SDEC_TYPE_LSB];
  assign hdr_size = rx_data[`SDEC_SIZE_MSB:0];

  always_comb begin
    case (hdr_type)
      sdec_pkg::SDEC_T_NIL, sdec_pkg::SDEC_T_BOOL: size_ok = (hdr_size == 3'h0);
      sdec_pkg::SDEC_T_UINT, sdec_pkg::SDEC_T_SINT: size_ok = (hdr_size <= 3'h4);
      sdec_pkg::SDEC_T_UUID: size_ok = (hdr_size == 3'h1) || (hdr_size == 3'h2) || (hdr_size == 3'h4);
      sdec_pkg::SDEC_T_TEXT, sdec_pkg::SDEC_T_SEQ, sdec_pkg::SDEC_T_ALT,
      sdec_pkg::SDEC_T_URL: size_ok = (hdr_size >= 3'h5);
      default: size_ok = 1'b0;
    endcase
  end

  // fixed data sizes, nil is empty
  always_comb begin
    fixed_len = 32'h1 << hdr_size;
    if (hdr_type == sdec_pkg::SDEC_T_NIL) begin
      fixed_len = 32'h0;
    end
  end

  always_comb begin
    case (size_q)
      3'h5: len_bytes = 3'h1;
      3'h6: len_bytes = 3'h2;
      default: len_bytes = 3'h4;
    endcase
  end

  assign len_next = {len_q[23:0], rx_data};

  // overrun of enclosing length
  // remaining count of the parent still includes this last length byte
  assign parent_overrun = (depth_q != 3'h0) && (state_q == sdec_pkg::SDEC_S_LEN) && (cnt_q == 3'h1)
    && (len_next + 32'h1 > remain_q[depth_q[1:0] - 2'h1]);
  assign plen_over = (state_q != sdec_pkg::SDEC_S_PDU) && (plen_q == 16'h0);
  assign elem_done = (len_q == 32'h1);

  always_comb begin
    ev_d = '0;
    ev_d.depth = depth_q;
    ev_d.data = rx_data;
    ev_d.elem_type = type_q;
    ev_d.size_idx = size_q;
    ev_d.length = len_q;
    case (state_q)
      sdec_pkg::SDEC_S_PDU: begin
        ev_d.kind = (cnt_q == 3'h0) ? sdec_pkg::SDEC_K_PDU_ID :
          (cnt_q < 3'h3) ? sdec_pkg::SDEC_K_TID : sdec_pkg::SDEC_K_PLEN;
        ev_d.last = (cnt_q == 3'h4);
      end
      sdec_pkg::SDEC_S_HDR: begin
        ev_d.kind = sdec_pkg::SDEC_K_HDR;
        ev_d.elem_type = hdr_type;
        ev_d.size_idx = hdr_size;
        ev_d.length = fixed_len;
        ev_d.error = !size_ok;
      end
      sdec_pkg::SDEC_S_LEN: begin
        ev_d.kind = sdec_pkg::SDEC_K_PLEN;
        ev_d.length = len_next;
        ev_d.last = (cnt_q == 3'h1);
        ev_d.error = parent_overrun;
      end
      default: begin
        ev_d.kind = sdec_pkg::SDEC_K_DATA;
        ev_d.last = elem_done;
      end
    endcase
    ev_d.error = ev_d.error || plen_over;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= sdec_pkg::SDEC_S_PDU;
      cnt_q <= 3'h0;
      type_q <= 5'h0;
      size_q <= 3'h0;
      len_q <= 32'h0;
    end else if (rx_start) begin
      state_q <= sdec_pkg::SDEC_S_PDU;
      cnt_q <= 3'h0;
    end else if (take) begin
      case (state_q)
        sdec_pkg::SDEC_S_PDU: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `SDEC_PDU_HDR_BYTES - 3'h1) begin
            cnt_q <= 3'h0;
            state_q <= sdec_pkg::SDEC_S_HDR;
          end
        end
        sdec_pkg::SDEC_S_HDR: begin
          type_q <= hdr_type;
          size_q <= hdr_size;
          len_q <= fixed_len;
          if (!size_ok) begin
            state_q <= sdec_pkg::SDEC_S_SKIP;
          end else if (hdr_size >= 3'h5) begin
            state_q <= sdec_pkg::SDEC_S_LEN;
            cnt_q <= (hdr_size == 3'h5) ? 3'h1 : (hdr_size == 3'h6) ? 3'h2 : 3'h4;
            len_q <= 32'h0;
          end else if (fixed_len != 32'h0) begin
            state_q <= sdec_pkg::SDEC_S_DATA;
          end
        end
        sdec_pkg::SDEC_S_LEN: begin
          len_q <= len_next;
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            // sequences and alternatives descend, and zero-length elements return, into the header state instead of data
            if (type_q == sdec_pkg::SDEC_T_SEQ || type_q == sdec_pkg::SDEC_T_ALT || len_next == 32'h0) begin
              state_q <= sdec_pkg::SDEC_S_HDR;
            end else begin
              state_q <= sdec_pkg::SDEC_S_DATA;
            end
          end
        end
        sdec_pkg::SDEC_S_DATA: begin
          len_q <= len_q - 32'h1;
          if (elem_done) begin
            state_q <= sdec_pkg::SDEC_S_HDR;
          end
        end
        default: begin
          // stays here until the next pdu start
          state_q <= sdec_pkg::SDEC_S_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      depth_q <= 3'h0;
      for (int i = 0; i < ND; i++) begin
        remain_q[i] <= 32'h0;
      end
    end else if (rx_start) begin
      depth_q <= 3'h0;
    end else if (take && state_q != sdec_pkg::SDEC_S_PDU) begin
      // every consumed byte counts against all open lists
      for (int i = 0; i < ND; i++) begin
        if (i < int'(depth_q) && remain_q[i] != 32'h0) begin
          remain_q[i] <= remain_q[i] - 32'h1;
        end
      end
      if (state_q == sdec_pkg::SDEC_S_LEN && cnt_q == 3'h1 && depth_q < 3'(ND)
          && (type_q == sdec_pkg::SDEC_T_SEQ || type_q == sdec_pkg::SDEC_T_ALT) && len_next != 32'h0) begin
        remain_q[depth_q[1:0]] <= len_next;
        depth_q <= depth_q + 3'h1;
      end else if (depth_q != 3'h0 && remain_q[depth_q[1:0] - 2'h1] == 32'h1 && state_q == sdec_pkg::SDEC_S_DATA) begin
        depth_q <= depth_q - 3'h1;
      end
    end
  end

  // sticky format error until next pdu
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= 1'b0;
    end else if (take && ((state_q == sdec_pkg::SDEC_S_HDR && !size_ok) || parent_overrun || plen_over)) begin
      err_q <= 1'b1;
    end else if (rx_start) begin
      err_q <= 1'b0;
    end
  end
  assign format_error = err_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pid_q <= 8'h0;
      tid_q <= 16'h0;
      plen_q <= 16'h0;
    end else if (take && state_q == sdec_pkg::SDEC_S_PDU) begin
      if (cnt_q == 3'h0) begin
        pid_q <= rx_data;
      end else if (cnt_q < 3'h3) begin
        tid_q <= {tid_q[7:0], rx_data};
      end else begin
        plen_q <= {plen_q[7:0], rx_data};
      end
    end else if (take && plen_q != 16'h0) begin
      plen_q <= plen_q - 16'h1;
    end
  end
  assign pdu_id = pid_q;
  assign pdu_tid = tid_q;
  assign pdu_id_reserved = (pid_q == 8'h00) || (pid_q > `SDEC_PDU_ID_MAX);

  sdec_fifo #(
    .WIDTH($bits(sdec_pkg::sdec_event_s)),
    .DEPTH(`SDEC_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(ev_d),
    .out_valid(ev_valid),
    .out_ready(ev_ready),
    .out_data(ev_data)
  );
endmodule

// ===== verilog/sdec_defines.svh
// constants for the service discovery element codec
`ifndef SDEC_DEFINES_SVH
`define SDEC_DEFINES_SVH
`define SDEC_TYPE_LSB 3
`define SDEC_SIZE_MSB 2
`define SDEC_PDU_HDR_BYTES 3'h5
`define SDEC_PDU_ID_MAX 8'h07
`define SDEC_TYPE_MAX 5'h08
`define SDEC_NEST_DEPTH 4
`define SDEC_FIFO_DEPTH 8
`endif

// ===== verilog/sdec_fifo.sv
// synchronous fifo for decoded events
`timescale 1ns/1ps
module sdec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ===== verilog/sdec_pkg.sv
// types for the service discovery element codec
package sdec_pkg;
  typedef enum logic [4:0] {
    SDEC_T_NIL = 5'h00,
    SDEC_T_UINT = 5'h01,
    SDEC_T_SINT = 5'h02,
    SDEC_T_UUID = 5'h03,
    SDEC_T_TEXT = 5'h04,
    SDEC_T_BOOL = 5'h05,
    SDEC_T_SEQ = 5'h06,
    SDEC_T_ALT = 5'h07,
    SDEC_T_URL = 5'h08
  } sdec_type_e;

  typedef enum logic [2:0] {
    SDEC_S_PDU = 3'b000,
    SDEC_S_HDR = 3'b001,
    SDEC_S_LEN = 3'b010,
    SDEC_S_DATA = 3'b011,
    SDEC_S_SKIP = 3'b100
  } sdec_state_e;

  // one decoded event, written into the output fifo
  typedef struct packed {
    logic [2:0] kind;
    logic [4:0] elem_type;
    logic [2:0] size_idx;
    logic [2:0] depth;
    logic [31:0] length;
    logic [7:0] data;
    logic last;
    logic error;
  } sdec_event_s;

  // kinds of decoded event
  typedef logic [2:0] sdec_kind_t;
  localparam sdec_kind_t SDEC_K_PDU_ID = 3'h0;
  localparam sdec_kind_t SDEC_K_TID = 3'h1;
  localparam sdec_kind_t SDEC_K_PLEN = 3'h2;
  localparam sdec_kind_t SDEC_K_HDR = 3'h3;
  localparam sdec_kind_t SDEC_K_DATA = 3'h4;
  localparam sdec_kind_t SDEC_K_END = 3'h5;
endpackage
